// ===== logic/timer_core_defs.svh
// Offsets, field positions, reset values for the prescaled timer core
// Assumes a 32-bit AHB-Lite slave decoding full byte addresses
`ifndef TIMER_CORE_DEFS_SVH
`define TIMER_CORE_DEFS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_EVENT_FLAG     32'hE000_4000
`define ADDR_RUN_CONTROL    32'hE000_4004
`define ADDR_MAIN_COUNTER   32'hE000_4008
`define ADDR_DIVIDER_LIMIT  32'hE000_400C
`define ADDR_DIVIDER_COUNT  32'hE000_4010
`define ADDR_COMPARE_ACTION 32'hE000_4014
`define ADDR_COMPARE_BASE   32'hE000_4018
`define ADDR_COUNT_SOURCE   32'hE000_4070

// ************************************************************
// Field positions
// ************************************************************
`define RUN_ENABLE_BIT      0
`define RUN_RESET_BIT       1
`define ACT_IRQ_BIT         0
`define ACT_RESET_BIT       1
`define ACT_STOP_BIT        2
`define NUM_COMPARE         4
`define NUM_CAPTURE         4

// ************************************************************
// Reset values
// ************************************************************
`define RST_RUN_CONTROL     8'h00
`define RST_COUNT_SOURCE    8'h00
`define RST_COUNTER         32'h0000_0000
`define RST_ACTION          12'h000

`endif

// ===== logic/timer_core_pkg.sv
// Types shared by the prescaled timer core
// Assumes the definitions header is included by users needing offsets
package timer_core_pkg;

  // ************************************************************
  // Count source modes, in field code order
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_RISE,
    MODE_FALL,
    MODE_BOTH
  } count_mode_e;

  // ************************************************************
  // Latched AHB address phase
  // ************************************************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } bus_phase_s;

  // Count source register layout
  typedef struct packed {
    logic [3:0]  rsvd;
    logic [1:0]  input_sel;
    count_mode_e mode;
  } count_source_s;

endpackage : timer_core_pkg

// ===== logic/prescaled_timer_counter_core.sv
// Prescaled 32-bit timer/counter core with four compare channels
// Assumes one AHB-Lite master; capture inputs are asynchronous pins
`timescale 1ns/100ps
`include "timer_core_defs.svh"

module prescaled_timer_counter_core
  import timer_core_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  capture_input,
  output logic      [3:0]  compare_match
);

  // ************************************************************
  // Declarations
  // ************************************************************
  bus_phase_s    dph_r;
  logic          rd_done_r;
  logic [31:0]   hrdata_r;
  logic [31:0]   rd_nxt;
  logic [7:0]    run_ctrl_r;
  count_source_s src_r;
  logic [31:0]   tc_r;
  logic [31:0]   pc_r;
  logic [31:0]   limit_r;
  logic [11:0]   action_r;
  logic [31:0]   cmp_r [`NUM_COMPARE];
  logic [3:0]    flag_r;
  logic [3:0]    cap_s1_r;
  logic [3:0]    cap_s2_r;
  logic          sel_prev_r;
  logic          sel_now;
  logic          rise;
  logic          fall;
  logic          tick;
  logic          run_en;
  logic          wr_commit;
  logic          wr_run;
  logic          wr_tc;
  logic          wr_pc;
  logic          wr_flag;
  logic [3:0]    match;
  logic [3:0]    irq_hit;
  logic          rst_hit;
  logic          stop_hit;
  logic          terminal;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  // Reads take one wait state so the answer comes from a flop
  // and already shows a write made just before it.
  assign hreadyout = !(dph_r.valid && !dph_r.write && !rd_done_r);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign wr_commit = dph_r.valid && dph_r.write && hready;
  assign wr_run    = wr_commit && dph_r.addr == `ADDR_RUN_CONTROL;
  assign wr_tc     = wr_commit && dph_r.addr == `ADDR_MAIN_COUNTER;
  assign wr_pc     = wr_commit && dph_r.addr == `ADDR_DIVIDER_COUNT;
  assign wr_flag   = wr_commit && dph_r.addr == `ADDR_EVENT_FLAG;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r     <= '0;
      rd_done_r <= 1'b0;
    end else if (hready) begin
      dph_r.valid <= hsel && htrans[1];
      dph_r.write <= hwrite;
      dph_r.addr  <= haddr;
      rd_done_r   <= 1'b0;
    end else if (dph_r.valid && !dph_r.write) begin
      rd_done_r <= 1'b1;
    end
  end

  // Read mux; reserved bits and unmapped addresses read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (dph_r.addr)
      `ADDR_EVENT_FLAG:     rd_nxt = {28'h000_0000, flag_r};
      `ADDR_RUN_CONTROL:    rd_nxt = {30'h0000_0000, run_ctrl_r[1:0]};
      `ADDR_MAIN_COUNTER:   rd_nxt = tc_r;
      `ADDR_DIVIDER_LIMIT:  rd_nxt = limit_r;
      `ADDR_DIVIDER_COUNT:  rd_nxt = pc_r;
      `ADDR_COMPARE_ACTION: rd_nxt = {20'h0_0000, action_r};
      `ADDR_COUNT_SOURCE:   rd_nxt = {28'h000_0000, src_r[3:0]};
      default: begin
        for (int i = 0; i < `NUM_COMPARE; i++) begin
          if (dph_r.addr == `ADDR_COMPARE_BASE + 32'(4 * i)) begin
            rd_nxt = cmp_r[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (dph_r.valid && !dph_r.write && !rd_done_r) begin
      hrdata_r <= rd_nxt;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ctrl_r <= `RST_RUN_CONTROL;
    end else if (stop_hit) begin
      run_ctrl_r[`RUN_ENABLE_BIT] <= 1'b0;
    end else if (wr_run) begin
      // Reserved bits are kept at zero whatever is written
      run_ctrl_r <= {6'h00, hwdata[1:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_r    <= `RST_COUNT_SOURCE;
      limit_r  <= `RST_COUNTER;
      action_r <= `RST_ACTION;
    end else if (wr_commit) begin
      if (dph_r.addr == `ADDR_COUNT_SOURCE) begin
        src_r <= {4'h0, hwdata[3:0]};
      end
      if (dph_r.addr == `ADDR_DIVIDER_LIMIT) begin
        limit_r <= hwdata;
      end
      if (dph_r.addr == `ADDR_COMPARE_ACTION) begin
        action_r <= hwdata[11:0];
      end
    end
  end

  // ************************************************************
  // Compare channels
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < `NUM_COMPARE; g++) begin : g_cmp
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_r[g] <= `RST_COUNTER;
        end else if (wr_commit &&
                     dph_r.addr == `ADDR_COMPARE_BASE + 32'(4 * g)) begin
          cmp_r[g] <= hwdata;
        end
      end
      assign match[g]   = tc_r == cmp_r[g];
      assign irq_hit[g] = match[g] && action_r[3*g + `ACT_IRQ_BIT];
    end
  endgenerate

  always_comb begin
    rst_hit  = 1'b0;
    stop_hit = 1'b0;
    for (int i = 0; i < `NUM_COMPARE; i++) begin
      rst_hit  = rst_hit  || (match[i] && action_r[3*i + `ACT_RESET_BIT]);
      stop_hit = stop_hit || (match[i] && action_r[3*i + `ACT_STOP_BIT]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_match <= 4'h0;
    end else begin
      compare_match <= match;
    end
  end

  // Set wins over a same-cycle clear so no match is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 4'h0;
    end else begin
      flag_r <= (flag_r & ~(wr_flag ? hwdata[3:0] : 4'h0))
                | irq_hit;
    end
  end

  // ************************************************************
  // Capture input sampling and edge detect
  // ************************************************************
  generate
    for (g = 0; g < `NUM_CAPTURE; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap_s1_r[g] <= 1'b0;
          cap_s2_r[g] <= 1'b0;
        end else begin
          cap_s1_r[g] <= capture_input[g];
          cap_s2_r[g] <= cap_s1_r[g];
        end
      end
    end
  endgenerate

  // Inputs must hold each level a full clock or edges are missed
  assign sel_now = cap_s2_r[src_r.input_sel];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= sel_now;
    end
  end

  assign rise = sel_now && !sel_prev_r;
  assign fall = !sel_now && sel_prev_r;

  always_comb begin
    unique case (src_r.mode)
      MODE_TIMER: tick = 1'b1;
      MODE_RISE:  tick = rise;
      MODE_FALL:  tick = fall;
      MODE_BOTH:  tick = rise || fall;
    endcase
  end

  // ************************************************************
  // Divider and main counter
  // ************************************************************
  assign run_en   = run_ctrl_r[`RUN_ENABLE_BIT] && !stop_hit;
  assign terminal = run_en && tick && pc_r == limit_r;

  // Reset bit outranks bus writes so counters stay at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= `RST_COUNTER;
    end else if (run_ctrl_r[`RUN_RESET_BIT]) begin
      pc_r <= `RST_COUNTER;
    end else if (wr_pc) begin
      pc_r <= hwdata;
    end else if (terminal) begin
      pc_r <= `RST_COUNTER;
    end else if (run_en && tick) begin
      pc_r <= pc_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc_r <= `RST_COUNTER;
    end else if (run_ctrl_r[`RUN_RESET_BIT]) begin
      tc_r <= `RST_COUNTER;
    end else if (wr_tc) begin
      tc_r <= hwdata;
    end else if (terminal && rst_hit) begin
      tc_r <= `RST_COUNTER;
    end else if (terminal) begin
      // Plain 32-bit add wraps to zero; no flag is raised
      tc_r <= tc_r + 32'h0000_0001;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hold_when_off: assert property (
    !run_ctrl_r[`RUN_ENABLE_BIT] && !run_ctrl_r[`RUN_RESET_BIT]
    && !wr_tc && !wr_pc |=> $stable(tc_r) && $stable(pc_r))
    else $error("counters moved while disabled");

  a_reset_clears: assert property (
    run_ctrl_r[`RUN_RESET_BIT] |=> tc_r == 32'h0000_0000
    && pc_r == 32'h0000_0000)
    else $error("reset bit did not clear counters");

  a_reset_holds: assert property (
    run_ctrl_r[`RUN_RESET_BIT] [*2] |=> pc_r == 32'h0000_0000
    && tc_r == 32'h0000_0000 && $stable(tc_r))
    else $error("counters left zero under reset bit");

  a_divider_step: assert property (
    run_en && tick && pc_r != limit_r && !run_ctrl_r[`RUN_RESET_BIT]
    && !wr_pc && !wr_tc |=> pc_r == $past(pc_r) + 32'h0000_0001
    && $stable(tc_r))
    else $error("divider did not step");

  a_terminal_step: assert property (
    terminal && !rst_hit && !run_ctrl_r[`RUN_RESET_BIT]
    && !wr_pc && !wr_tc |=> pc_r == 32'h0000_0000
    && tc_r == $past(tc_r) + 32'h0000_0001)
    else $error("terminal count did not step main counter");

  a_edge_gate: assert property (
    src_r.mode != MODE_TIMER && !tick && !run_ctrl_r[`RUN_RESET_BIT]
    && !wr_pc && !wr_tc |=> $stable(pc_r) && $stable(tc_r))
    else $error("counter moved without qualifying edge");

  a_stop_match: assert property (
    stop_hit |=> !run_ctrl_r[`RUN_ENABLE_BIT])
    else $error("stop on match kept enable set");

  a_match_reset: assert property (
    terminal && rst_hit && !run_ctrl_r[`RUN_RESET_BIT] && !wr_tc
    |=> tc_r == 32'h0000_0000)
    else $error("reset on match did not clear counter");

  a_match_flag: assert property (
    irq_hit != 4'h0 |=> (flag_r & $past(irq_hit)) == $past(irq_hit))
    else $error("match flag not set");

  a_flag_clear: assert property (
    wr_flag && irq_hit == 4'h0
    |=> flag_r == ($past(flag_r) & ~$past(hwdata[3:0])))
    else $error("flag write one to clear misbehaved");

  a_read_wait: assert property (
    hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer not one wait state");

endmodule : prescaled_timer_counter_core

// ===== testbench/capture_pin_model.sv
// Model of the external pins that feed the capture inputs
// Assumes the bench pulses go for one clock with mask and count set
`timescale 1ns/100ps
module capture_pin_model (
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [3:0] pin_mask,
  input  wire logic [7:0] pulses,
  output logic            busy,
  output logic      [3:0] capture_input
);
  logic [7:0] left_r = 8'h00;
  logic [1:0] ph_r   = 2'h0;
  logic [3:0] slow;
  always_ff @(posedge hclk) begin
    if (go) begin
      left_r <= pulses;
      ph_r   <= 2'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) left_r <= left_r - 8'h01;
    end
  end
  assign busy = (left_r != 8'h00);
  // Masked pins 2 clocks high, 2 low
  assign slow = (ph_r < 2'h2) ? pin_mask : 4'h0;
  // Other pins toggle every clock, the fastest legal rate, as a decoy
  assign capture_input = busy ? (slow | (~pin_mask & {4{ph_r[0]}})) : 4'h0;
endmodule : capture_pin_model

// ===== testbench/tb_top.sv
// Self-checking bench for the prescaled timer core
// Assumes the core is the only AHB-Lite slave; hready is its hreadyout
`timescale 1ns/100ps
`include "timer_core_defs.svh"
module tb_top import timer_core_pkg::*; ;
  logic        hclk     = 1'b0;
  logic        hresetn  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        go       = 1'b0;
  logic [3:0]  pin_mask = 4'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  compare_match;
  logic [3:0]  capture_input;
  logic        busy;
  logic        rdy_s    = 1'b1;
  logic [31:0] rd_s;
  int          err_count  = 0;
  int          n_compared = 0;

  always #5 hclk = ~hclk;
  // Settled copies, so no edge races with the slave's own updates
  always @(negedge hclk) begin
    rdy_s <= hreadyout;
    rd_s  <= hrdata;
  end

  prescaled_timer_counter_core i_prescaled_timer_counter_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_input(capture_input),
    .compare_match(compare_match));
  capture_pin_model i_capture_pin_model (
    .hclk(hclk), .go(go), .pin_mask(pin_mask), .pulses(8'h05),
    .busy(busy), .capture_input(capture_input));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (rdy_s !== 1'b1) @(posedge hclk);
    rd = rd_s;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(what, x, exp);
  endtask : rd_chk

  task automatic wait_stop();
    logic [31:0] x;
    x = 32'h0000_0001;
    while (x[0] !== 1'b0) bus(1'b0, `ADDR_RUN_CONTROL, 32'h0000_0000, x);
  endtask : wait_stop

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values();
    rd_chk("run_control", `ADDR_RUN_CONTROL, 32'h0000_0000);
    rd_chk("count_source", `ADDR_COUNT_SOURCE, 32'h0000_0000);
    rd_chk("unmapped", 32'hE000_4028, 32'h0000_0000);
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask : t_reset_values

  task automatic t_stop_match();
    wr(`ADDR_COMPARE_BASE, 32'h0000_0005);
    wr(`ADDR_DIVIDER_LIMIT, 32'h0000_0001);
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0004);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0001);
    wait_stop();
    rd_chk("limit", `ADDR_DIVIDER_LIMIT, 32'h0000_0001);
    rd_chk("main", `ADDR_MAIN_COUNTER, 32'h0000_0005);
    rd_chk("divider", `ADDR_DIVIDER_COUNT, 32'h0000_0000);
    check("match", {28'h0, compare_match}, 32'h0000_0001);
    wr(`ADDR_DIVIDER_COUNT, 32'h0000_0007);
    rd_chk("div load", `ADDR_DIVIDER_COUNT, 32'h0000_0007);
    rd_chk("main held", `ADDR_MAIN_COUNTER, 32'h0000_0005);
  endtask : t_stop_match

  task automatic t_reset_bit();
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0000);
    wr(`ADDR_MAIN_COUNTER, 32'h0000_0009);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0003);
    rd_chk("main rst", `ADDR_MAIN_COUNTER, 32'h0000_0000);
    rd_chk("div rst", `ADDR_DIVIDER_COUNT, 32'h0000_0000);
    wr(`ADDR_MAIN_COUNTER, 32'h0000_0004);
    rd_chk("main hold", `ADDR_MAIN_COUNTER, 32'h0000_0000);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0000);
    wr(`ADDR_MAIN_COUNTER, 32'h0000_0004);
    rd_chk("main free", `ADDR_MAIN_COUNTER, 32'h0000_0004);
  endtask : t_reset_bit

  task automatic t_match_reset();
    wr(`ADDR_MAIN_COUNTER, 32'h0000_0001);
    wr(`ADDR_DIVIDER_LIMIT, 32'h0000_0000);
    wr(`ADDR_COMPARE_BASE, 32'h0000_0003);
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0022);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0001);
    wait_stop();
    rd_chk("main clr", `ADDR_MAIN_COUNTER, 32'h0000_0000);
  endtask : t_match_reset

  task automatic t_wrap_flags();
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0000);
    wr(`ADDR_MAIN_COUNTER, 32'hFFFF_FFFE);
    wr(`ADDR_COMPARE_BASE, 32'h0000_0001);
    wr(`ADDR_EVENT_FLAG, 32'h0000_000F);
    wr(`ADDR_COMPARE_ACTION, 32'h0000_000C);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0001);
    wait_stop();
    rd_chk("wrap", `ADDR_MAIN_COUNTER, 32'h0000_0001);
    rd_chk("flags", `ADDR_EVENT_FLAG, 32'h0000_0002);
    wr(`ADDR_EVENT_FLAG, 32'h0000_0000);
    rd_chk("flags keep", `ADDR_EVENT_FLAG, 32'h0000_0002);
    wr(`ADDR_EVENT_FLAG, 32'h0000_0002);
    rd_chk("flags clr", `ADDR_EVENT_FLAG, 32'h0000_0000);
  endtask : t_wrap_flags

  // Upper two channels: irq on channel 2, stop on channel 3
  task automatic t_chan_hi();
    wr(`ADDR_MAIN_COUNTER, 32'h0000_000E);
    wr(`ADDR_COMPARE_BASE + 32'h0000_0008, 32'h0000_0010);
    wr(`ADDR_COMPARE_BASE + 32'h0000_000C, 32'h0000_0012);
    rd_chk("c2", `ADDR_COMPARE_BASE + 32'h0000_0008, 32'h0000_0010);
    rd_chk("c3", `ADDR_COMPARE_BASE + 32'h0000_000C, 32'h0000_0012);
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0840);
    wr(`ADDR_RUN_CONTROL, 32'h0000_0001);
    wait_stop();
    rd_chk("stop c3", `ADDR_MAIN_COUNTER, 32'h0000_0012);
    rd_chk("flag c2", `ADDR_EVENT_FLAG, 32'h0000_0004);
  endtask : t_chan_hi

  task automatic t_count_edges();
    count_source_s cs;
    logic [31:0]   exp_n;
    wr(`ADDR_COMPARE_ACTION, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      cs.rsvd      = 4'h0;
      cs.input_sel = i[1:0];
      cs.mode      = count_mode_e'(i % 3 + 1);
      wr(`ADDR_MAIN_COUNTER, 32'h0000_0000);
      wr(`ADDR_COUNT_SOURCE, {24'h0, cs});
      rd_chk("source", `ADDR_COUNT_SOURCE, {24'h0, cs});
      wr(`ADDR_RUN_CONTROL, 32'h0000_0001);
      pin_mask <= 4'h1 << i;
      go       <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      @(negedge hclk);
      while (busy) @(negedge hclk);
      // Pin to counter latency is 3 clocks; 8 leaves margin
      repeat (8) @(posedge hclk);
      wr(`ADDR_RUN_CONTROL, 32'h0000_0000);
      exp_n = (cs.mode == MODE_BOTH) ? 32'h0000_000A : 32'h0000_0005;
      rd_chk("edges", `ADDR_MAIN_COUNTER, exp_n);
    end
  endtask : t_count_edges

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_stop_match();
    t_reset_bit();
    t_match_reset();
    t_wrap_flags();
    t_chan_hi();
    t_count_edges();
    report_and_stop();
  end

  // Whole run needs about 350 clocks
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    report_and_stop();
  end
endmodule : tb_top
